// ==== fcse_card_model.sv ====
// behavioural flash card: six-write sector erase, erase timer, status reads and busy line
`timescale 1ns/10ps
module fcse_card_model #(
	parameter int TMO_CYC = fcse_pkg::ERASE_TMO_CYC,
	parameter int ERASE_CYC = 300
) (
	input wire logic clk,
	input wire logic [fcse_pkg::CARD_AW-1:0] card_addr,
	input wire logic [fcse_pkg::DW-1:0] card_wdata,
	input wire logic low_byte_enable_n,
	input wire logic high_byte_enable_n,
	input wire logic write_enable_n,
	input wire logic output_enable_n,
	output logic [fcse_pkg::DW-1:0] card_rdata,
	output logic ready_busy_line
);
	import fcse_pkg::*;
	logic [7:0] seq [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h30};
	logic [5:0] sect = 6'h00;
	logic [7:0] cmd;
	logic [15:0] noise = 16'h0000;
	int step = 0;
	int tmo = 0;
	int ers = 0;
	int n_done = 0;
	int n_abort = 0;

	always @(posedge write_enable_n) begin
		cmd = low_byte_enable_n ? card_wdata[15:8] : card_wdata[7:0];
		if (cmd == 8'hF0) begin
			if (tmo > 0 || ers > 0)
				n_abort++;
			tmo = 0;
			ers = 0;
			step = 0;
		end else if (step == 6 && cmd == 8'h30 && tmo > 0)
			tmo = TMO_CYC;
		else if (tmo == 0 && ers == 0 && cmd == seq[step]) begin
			step++;
			if (step == 6) begin
				sect = card_addr[21:16];
				tmo = TMO_CYC;
			end
		end else begin
			step = 0;
			tmo = 0;
		end
	end

	// zeroing and erase are folded into one self-timed span with no host involvement
	// timers move on the falling edge so the host never sees its inputs change at its sampling edge
	always @(negedge clk) begin
		noise = noise + 16'h1357;
		if (tmo == 1)
			ers = ERASE_CYC;
		if (tmo > 0)
			tmo--;
		else if (ers > 0) begin
			ers--;
			if (ers == 0) begin
				n_done++;
				step = 0;
			end
		end
	end

	assign ready_busy_line = (tmo == 0 && ers == 0);
	// an unselected bus shows a changing pattern, never the last value
	assign card_rdata = (output_enable_n || (low_byte_enable_n && high_byte_enable_n)) ? ~noise :
		((tmo > 0 || ers > 0) && card_addr[21:16] == sect) ? (noise & 16'h7F7F) : 16'hFFFF;
endmodule : fcse_card_model

// ==== fcse_cycle.sv ====
// one card bus cycle: enables, write or output strobe, hold
`timescale 1ns/10ps
module fcse_cycle (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic wr,
	input wire logic [fcse_pkg::CARD_AW-1:0] addr,
	input wire logic cel_n,
	input wire logic ceh_n,
	input wire logic [fcse_pkg::DW-1:0] wdata,
	input wire logic [fcse_pkg::DW-1:0] card_rdata,
	output logic done,
	output logic [fcse_pkg::DW-1:0] rdata,
	output logic [fcse_pkg::CARD_AW-1:0] card_addr,
	output logic [fcse_pkg::DW-1:0] card_wdata,
	output logic card_data_oe,
	output logic low_byte_enable_n,
	output logic high_byte_enable_n,
	output logic write_enable_n,
	output logic output_enable_n
);
	import fcse_pkg::*;
	typedef enum logic [3:0] {
		CY_IDLE = 4'b0001,
		CY_SETUP = 4'b0010,
		CY_STROBE = 4'b0100,
		CY_HOLD = 4'b1000
	} fcse_phase_type;
	typedef struct packed {
		fcse_phase_type ph;
		logic [3:0] cnt;
		logic wr;
		logic done;
		logic [DW-1:0] rdata;
		logic [CARD_AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic oe;
		logic cel_n;
		logic ceh_n;
		logic we_n;
		logic re_n;
	} fcse_cycle_type;
	fcse_cycle_type s_reg, s_next;

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		unique case (s_reg.ph)
			CY_IDLE: if (start) begin
				// address stays on the pins after the cycle, so polls keep it
				s_next.addr = addr;
				s_next.wdata = wdata;
				s_next.wr = wr;
				s_next.oe = wr;
				s_next.cel_n = cel_n;
				s_next.ceh_n = ceh_n;
				s_next.ph = CY_SETUP;
			end
			CY_SETUP: begin
				s_next.we_n = ~s_reg.wr;
				s_next.re_n = s_reg.wr;
				s_next.cnt = s_reg.wr ? 4'(WE_PULSE_CYC - 1) : 4'(READ_ACC_CYC - 1);
				s_next.ph = CY_STROBE;
			end
			CY_STROBE: if (s_reg.cnt == 4'h0) begin
				// the card latches the command on this rising write strobe
				s_next.we_n = 1'b1;
				s_next.re_n = 1'b1;
				if (!s_reg.wr)
					s_next.rdata = card_rdata;
				s_next.ph = CY_HOLD;
			end else begin
				s_next.cnt = s_reg.cnt - 4'h1;
			end
			CY_HOLD: begin
				s_next.cel_n = 1'b1;
				s_next.ceh_n = 1'b1;
				s_next.oe = 1'b0;
				s_next.done = 1'b1;
				s_next.ph = CY_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.ph <= CY_IDLE;
			s_reg.cel_n <= 1'b1;
			s_reg.ceh_n <= 1'b1;
			s_reg.we_n <= 1'b1;
			s_reg.re_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign done = s_reg.done;
	assign rdata = s_reg.rdata;
	assign card_addr = s_reg.addr;
	assign card_wdata = s_reg.wdata;
	assign card_data_oe = s_reg.oe;
	assign low_byte_enable_n = s_reg.cel_n;
	assign high_byte_enable_n = s_reg.ceh_n;
	assign write_enable_n = s_reg.we_n;
	assign output_enable_n = s_reg.re_n;
endmodule : fcse_cycle

// ==== fcse_host.sv ====
// host controller that issues a sector erase to the card and waits for it to end
`timescale 1ns/10ps
module fcse_host (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	input wire logic [fcse_pkg::DW-1:0] card_rdata,
	input wire logic ready_busy_line,
	output logic [fcse_pkg::CARD_AW-1:0] card_addr,
	output logic [fcse_pkg::DW-1:0] card_wdata,
	output logic card_data_oe,
	output logic low_byte_enable_n,
	output logic high_byte_enable_n,
	output logic write_enable_n,
	output logic output_enable_n
);
	import fcse_pkg::*;
	typedef enum logic [4:0] {
		FC_IDLE = 5'b00001,
		FC_CMD = 5'b00010,
		FC_GAP = 5'b00100,
		FC_POLL = 5'b01000,
		FC_ABORT = 5'b10000
	} fcse_state_type;
	typedef struct packed {
		fcse_state_type st;
		logic [2:0] step;
		logic [HOST_AW-1:0] addr;
		logic word;
		logic big;
		logic use_busy;
		logic abort_pend;
		logic wait_cyc;
		logic cyc_start;
		logic cyc_wr;
		logic [DW-1:0] cyc_data;
		logic [11:0] gap;
		logic [NUM_EV-1:0] stat;
		logic [NUM_EV-1:0] mask;
		logic irq;
		logic ack;
		logic [31:0] dat_o;
		logic [DW-1:0] last;
	} fcse_main_type;
	fcse_main_type s_reg, s_next;
	logic cyc_done;
	logic [DW-1:0] cyc_rdata;

	fcse_cycle u_cycle (
		.clk(clk),
		.rst(rst),
		.start(s_reg.cyc_start),
		.wr(s_reg.cyc_wr),
		// enables and address come from the stored host address, so every poll reuses them
		.addr(card_of(s_reg.addr, s_reg.big)),
		.cel_n(s_reg.word ? 1'b0 : s_reg.addr[0]),
		.ceh_n(s_reg.word ? 1'b0 : ~s_reg.addr[0]),
		.wdata(s_reg.cyc_data),
		.card_rdata(card_rdata),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.card_addr(card_addr),
		.card_wdata(card_wdata),
		.card_data_oe(card_data_oe),
		.low_byte_enable_n(low_byte_enable_n),
		.high_byte_enable_n(high_byte_enable_n),
		.write_enable_n(write_enable_n),
		.output_enable_n(output_enable_n)
	);

	always_comb begin
		logic acc;
		logic start_req;
		logic abort_req;
		logic kick;
		logic kick_wr;
		logic [7:0] kick_cmd;
		logic [NUM_EV-1:0] ev;
		logic [NUM_EV-1:0] clr;
		logic [31:0] w;
		acc = 1'b0;
		start_req = 1'b0;
		abort_req = 1'b0;
		kick = 1'b0;
		kick_wr = 1'b1;
		kick_cmd = CMD_RESET;
		ev = '0;
		clr = '0;
		w = '0;
		s_next = s_reg;
		s_next.cyc_start = 1'b0;
		s_next.ack = 1'b0;
		if (cyc_done)
			s_next.wait_cyc = 1'b0;
		// registered ack: a request still up in the ack cycle is not taken twice
		acc = wb_cyc_i && wb_stb_i && !s_reg.ack;
		if (acc) begin
			s_next.ack = 1'b1;
			unique case (wb_adr_i)
				REG_CTRL: s_next.dat_o = {27'h0, s_reg.use_busy, s_reg.big, s_reg.word, s_reg.abort_pend, 1'b0};
				REG_ADDR: s_next.dat_o = {9'h0, s_reg.addr};
				// sector number and pair of the stored address, seen from the card side
				REG_STATUS: s_next.dat_o = {s_reg.last, 2'h0, s_reg.addr[PAIR_BIT+1] & s_reg.big,
					s_reg.addr[SECTOR_MSB+1:SECTOR_LSB+1], 6'h0, ready_busy_line, s_reg.st != FC_IDLE};
				REG_IRQ_STAT: s_next.dat_o = {29'h0, s_reg.stat};
				REG_IRQ_MASK: s_next.dat_o = {29'h0, s_reg.mask};
				default: s_next.dat_o = 32'h0;
			endcase
			if (wb_we_i) begin
				unique case (wb_adr_i)
					REG_CTRL: begin
						w = wmask(32'h0, wb_dat_i, wb_sel_i);
						start_req = w[CTRL_START];
						abort_req = w[CTRL_ABORT];
						// mode and address only move while idle, so the pins stay coherent
						if (s_reg.st == FC_IDLE) begin
							w = wmask({27'h0, s_reg.use_busy, s_reg.big, s_reg.word, 2'h0}, wb_dat_i, wb_sel_i);
							s_next.word = w[CTRL_WORD];
							s_next.big = w[CTRL_BIG];
							s_next.use_busy = w[CTRL_BUSY_MODE];
						end
					end
					REG_ADDR: if (s_reg.st == FC_IDLE) begin
						w = wmask({9'h0, s_reg.addr}, wb_dat_i, wb_sel_i);
						s_next.addr = w[HOST_AW-1:0];
					end
					REG_IRQ_STAT: begin
						w = wmask(32'h0, wb_dat_i, wb_sel_i);
						clr = w[NUM_EV-1:0];
					end
					REG_IRQ_MASK: begin
						w = wmask({29'h0, s_reg.mask}, wb_dat_i, wb_sel_i);
						s_next.mask = w[NUM_EV-1:0];
					end
					default: ;
				endcase
			end
		end
		if (abort_req && s_reg.st != FC_IDLE)
			s_next.abort_pend = 1'b1;
		unique case (s_reg.st)
			FC_IDLE: begin
				s_next.abort_pend = 1'b0;
				if (start_req) begin
					s_next.step = 3'h0;
					kick = 1'b1;
					kick_cmd = cmd_step(3'h0);
					s_next.st = FC_CMD;
				end
			end
			FC_CMD: if (cyc_done) begin
				if (s_next.abort_pend) begin
					kick = 1'b1;
					s_next.st = FC_ABORT;
				end else if (s_reg.step == LAST_STEP) begin
					// the card's own 100 us timer runs first; only the busy line needs it
					s_next.gap = s_reg.use_busy ? 12'(ERASE_TMO_CYC - 1) : 12'(POLL_GAP_CYC - 1);
					s_next.st = FC_GAP;
				end else begin
					s_next.step = s_reg.step + 3'h1;
					kick = 1'b1;
					kick_cmd = cmd_step(s_reg.step + 3'h1);
				end
			end
			FC_GAP: if (s_next.abort_pend) begin
				kick = 1'b1;
				s_next.st = FC_ABORT;
			end else if (s_reg.gap == 12'h0) begin
				s_next.st = FC_POLL;
				if (!s_reg.use_busy) begin
					kick = 1'b1;
					kick_wr = 1'b0;
				end
			end else begin
				s_next.gap = s_reg.gap - 12'h1;
			end
			// the busy line needs no address, so watching it leaves the card pins untouched
			FC_POLL: if (s_reg.use_busy) begin
				if (ready_busy_line) begin
					ev[EV_DONE] = 1'b1;
					s_next.st = FC_IDLE;
				end else begin
					s_next.gap = 12'(POLL_GAP_CYC - 1);
					s_next.st = FC_GAP;
				end
			end else if (cyc_done) begin
				s_next.last = cyc_rdata;
				// the polled bit reads zero while the card is still erasing
				if (status_ok(cyc_rdata, s_reg.word, s_reg.addr[0])) begin
					ev[EV_DONE] = 1'b1;
					s_next.st = FC_IDLE;
				end else begin
					s_next.gap = 12'(POLL_GAP_CYC - 1);
					s_next.st = FC_GAP;
				end
			end
			FC_ABORT: if (cyc_done) begin
				// sector contents are now undefined; software must erase it again
				ev[EV_ABORT] = 1'b1;
				s_next.abort_pend = 1'b0;
				s_next.st = FC_IDLE;
			end
		endcase
		if (start_req && s_reg.st != FC_IDLE)
			ev[EV_REFUSED] = 1'b1;
		if (kick) begin
			s_next.cyc_start = 1'b1;
			s_next.cyc_wr = kick_wr;
			// lanes follow a mode written together with start, so the first unlock matches the enables
			s_next.cyc_data = lane_data(kick_cmd, s_next.word, s_next.addr[0]);
			s_next.wait_cyc = 1'b1;
		end
		// a clear meeting a new event in the same cycle loses, so no event is missed
		s_next.stat = (s_reg.stat & ~clr) | ev;
		s_next.irq = |(s_next.stat & s_next.mask);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.st <= FC_IDLE;
			{s_reg.use_busy, s_reg.big, s_reg.word} <= MODE_RST;
			s_reg.mask <= MASK_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.dat_o;
	assign irq = s_reg.irq;

	// checks on the pins toward the card and on the event flags
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_word_both_en: assert property ((s_reg.word && !write_enable_n) |-> (!low_byte_enable_n && !high_byte_enable_n))
		else $error("word write without both byte enables");
	a_byte_lane_sel: assert property ((!s_reg.word && (!write_enable_n || !output_enable_n))
		|-> (low_byte_enable_n == s_reg.addr[0] && high_byte_enable_n == !s_reg.addr[0]))
		else $error("byte enable does not follow host A0");
	a_card_addr_map: assert property ((s_reg.st != FC_IDLE && !write_enable_n)
		|-> card_addr == {s_reg.addr[HOST_AW-1] & s_reg.big, s_reg.addr[HOST_AW-2:1]})
		else $error("card address is not host address shifted");
	a_abort_reset_cmd: assert property ((s_reg.st == FC_ABORT && !write_enable_n)
		|-> (card_wdata[7:0] == CMD_RESET || card_wdata[15:8] == CMD_RESET))
		else $error("abort write is not the reset command");
	a_poll_in_sector: assert property ((s_reg.st == FC_POLL && !output_enable_n)
		|-> card_addr[SECTOR_MSB:SECTOR_LSB] == s_reg.addr[SECTOR_MSB+1:SECTOR_LSB+1])
		else $error("poll outside the erasing sector");
	a_done_on_status: assert property ((s_reg.st == FC_POLL && !s_reg.use_busy && cyc_done
		&& status_ok(cyc_rdata, s_reg.word, s_reg.addr[0])) |=> (s_reg.st == FC_IDLE && s_reg.stat[EV_DONE]))
		else $error("completed status not taken");
	a_addr_stable: assert property ((s_reg.st == FC_GAP && $past(s_reg.st) != FC_IDLE) |-> $stable(card_addr))
		else $error("sector address moved during erase");
	a_last_write_30: assert property ((s_reg.st == FC_CMD && s_reg.step == LAST_STEP && !write_enable_n)
		|-> (card_wdata[7:0] == CMD_SECTOR_ERASE || card_wdata[15:8] == CMD_SECTOR_ERASE))
		else $error("sixth write is not the erase command");
	a_busy_line_done: assert property ((s_reg.st == FC_POLL && s_reg.use_busy && ready_busy_line)
		|=> (s_reg.st == FC_IDLE && s_reg.stat[EV_DONE]))
		else $error("ready line not taken as completion");

	// command sequence and bus direction
	a_one_in_flight: assert property ((s_reg.wait_cyc && !cyc_done) |=> !s_reg.cyc_start)
		else $error("card cycle started while another is in flight");
	a_unlock_order: assert property ((s_reg.st == FC_CMD && !write_enable_n)
		|-> (card_wdata[7:0] == cmd_step(s_reg.step) || card_wdata[15:8] == cmd_step(s_reg.step)))
		else $error("command write out of order");
	a_write_drives_bus: assert property (!write_enable_n |-> card_data_oe)
		else $error("write strobe without data drive");
	a_read_bus_free: assert property (!output_enable_n |-> (!card_data_oe && write_enable_n))
		else $error("data driven during a poll read");
	a_idle_pins_quiet: assert property (s_reg.st == FC_IDLE |-> (write_enable_n && output_enable_n))
		else $error("card strobe while idle");
	a_no_resend: assert property (s_reg.st == FC_GAP |=> s_reg.st != FC_CMD)
		else $error("command sequence sent again during erase");
	a_gap_timer_busy: assert property ((s_reg.st == FC_CMD && s_reg.step == LAST_STEP && cyc_done
		&& s_reg.use_busy && !s_reg.abort_pend && !(wb_cyc_i && wb_stb_i)) |=> s_reg.gap == 12'(ERASE_TMO_CYC - 1))
		else $error("busy mode does not wait out the card timer");

	// completion, abort and refusal
	a_no_write_poll: assert property ((s_reg.st == FC_GAP || s_reg.st == FC_POLL) |-> write_enable_n)
		else $error("write strobe while waiting for completion");
	a_addr_frozen: assert property ((s_reg.st != FC_IDLE && $past(s_reg.st) != FC_IDLE)
		|-> ($stable(s_reg.addr) && $stable(s_reg.word) && $stable(s_reg.big)))
		else $error("stored sector address changed during erase");
	a_abort_ends_idle: assert property ((s_reg.st == FC_ABORT && cyc_done)
		|=> (s_reg.st == FC_IDLE && s_reg.stat[EV_ABORT]))
		else $error("abort not reported after the reset write");
	a_abort_idle_clear: assert property (s_reg.st == FC_IDLE |=> !s_reg.abort_pend)
		else $error("abort left pending while idle");
	a_start_refused: assert property ((s_reg.st != FC_IDLE && wb_cyc_i && wb_stb_i && wb_we_i
		&& !wb_ack_o && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START]) |=> s_reg.stat[EV_REFUSED])
		else $error("start during erase not refused");
endmodule : fcse_host

// ==== fcse_pkg.sv ====
// constants and helper functions for the sector erase host controller
// Summary of operation
// - word access drives both byte enables low
// - host A0 picks byte enable, rest shifts down
// - host supplies A0..A21 or A0..A22 by size
// - reset command aborts erase, sector left undefined
// - host polls at any address in erasing sector
// - host polls with a valid sector address
// - host holds or restores sector address while polling
// - host issues six writes ending with 30h
package fcse_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int WE_PULSE_NS = 100;
	localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_ACC_NS = 150;
	localparam int READ_ACC_CYC = (READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POLL_GAP_NS = 1000;
	localparam int POLL_GAP_CYC = (POLL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_TMO_US = 100;
	localparam int ERASE_TMO_CYC = (ERASE_TMO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOST_AW = 23;
	localparam int CARD_AW = 22;
	localparam int DW = 16;
	localparam int SECTOR_LSB = 16;
	localparam int SECTOR_MSB = 20;
	localparam int PAIR_BIT = 21;
	localparam int EVEN_STATUS_POS = 7;
	localparam int ODD_STATUS_POS = 15;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;
	localparam int CTRL_START = 0;
	localparam int CTRL_ABORT = 1;
	localparam int CTRL_WORD = 2;
	localparam int CTRL_BIG = 3;
	localparam int CTRL_BUSY_MODE = 4;
	localparam int NUM_EV = 3;
	localparam int EV_DONE = 0;
	localparam int EV_ABORT = 1;
	localparam int EV_REFUSED = 2;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [NUM_EV-1:0] MASK_RST = 3'h0;
	localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_SETUP = 8'h80;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [2:0] LAST_STEP = 3'h5;

	function automatic logic [7:0] cmd_step(input logic [2:0] step);
		unique case (step)
			3'h0, 3'h3: cmd_step = CMD_UNLOCK1;
			3'h1, 3'h4: cmd_step = CMD_UNLOCK2;
			3'h2: cmd_step = CMD_SETUP;
			default: cmd_step = CMD_SECTOR_ERASE;
		endcase
	endfunction : cmd_step

	// commands sit on the lane of the byte addressed, on both lanes for a word pair
	function automatic logic [DW-1:0] lane_data(input logic [7:0] cmd, input logic word, input logic a0);
		if (word)
			lane_data = {cmd, cmd};
		else if (a0)
			lane_data = {cmd, 8'h00};
		else
			lane_data = {8'h00, cmd};
	endfunction : lane_data

	function automatic logic [CARD_AW-1:0] card_of(input logic [HOST_AW-1:0] host, input logic big);
		card_of = host[HOST_AW-1:1];
		if (!big)
			card_of[PAIR_BIT] = 1'b0;
	endfunction : card_of

	function automatic logic status_ok(input logic [DW-1:0] d, input logic word, input logic a0);
		if (word)
			status_ok = d[EVEN_STATUS_POS] & d[ODD_STATUS_POS];
		else
			status_ok = a0 ? d[ODD_STATUS_POS] : d[EVEN_STATUS_POS];
	endfunction : status_ok

	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
			wmask[i*8 +: 8] = sel[i] ? nv[i*8 +: 8] : old[i*8 +: 8];
	endfunction : wmask
endpackage : fcse_pkg

// ==== tb_top.sv ====
// self-checking bench: erase in every lane mode, busy mode, masking, refusal and abort
`timescale 1ns/10ps
module tb_top;
	import fcse_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic wen = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] q;
	logic [31:0] dat_o;
	logic ack, irq, rb, oe_d, cel_n, ceh_n, we_n, oe_n;
	logic [15:0] rdata, wdata;
	logic [21:0] caddr;
	logic [21:0] exp_ca = 22'h0;
	logic [39:0] wq[$];
	logic [7:0] seq [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h30};
	logic [7:0] rz [4] = '{REG_CTRL, REG_IRQ_STAT, REG_IRQ_MASK, 8'h14};
	int n_fail = 0;
	int n_checks = 0;

	fcse_host i_fcse_host (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq), .card_rdata(rdata),
		.ready_busy_line(rb), .card_addr(caddr), .card_wdata(wdata), .card_data_oe(oe_d),
		.low_byte_enable_n(cel_n), .high_byte_enable_n(ceh_n), .write_enable_n(we_n), .output_enable_n(oe_n));
	fcse_card_model i_fcse_card_model (.clk(clk), .card_addr(caddr), .card_wdata(wdata),
		.low_byte_enable_n(cel_n), .high_byte_enable_n(ceh_n), .write_enable_n(we_n),
		.output_enable_n(oe_n), .card_rdata(rdata), .ready_busy_line(rb));

	initial forever #12.5 clk = ~clk;

	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		wen <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20)
			chk(1'b0, 1'b1, "no bus answer");
		@(posedge clk);
	endtask : wb

	// command writes as the card sees them: address, data, both enables
	always @(posedge we_n)
		if (!rst) begin
			wq.push_back({caddr, wdata, cel_n, ceh_n});
			chk(oe_d, 1'b1, "data not driven on write");
		end
	always @(posedge oe_n)
		if (!rst) begin
			chk(caddr, exp_ca, "poll address");
			chk(oe_d, 1'b0, "data driven on read");
		end

	task automatic erase(input logic [22:0] ha, input logic [4:0] md, input logic [2:0] mk);
		logic [15:0] c;
		logic seen;
		int n0;
		int n;
		n0 = i_fcse_card_model.n_done;
		exp_ca = {md[3] & ha[22], ha[21:1]};
		seen = 1'b0;
		n = 0;
		wq.delete();
		wb(1'b1, REG_IRQ_MASK, {29'h0, mk});
		wb(1'b1, REG_ADDR, {9'h0, ha});
		wb(1'b1, REG_CTRL, {27'h0, md});
		do begin
			wb(1'b0, REG_STATUS, 32'h0);
			seen |= (q[1:0] === 2'b01);
			n++;
		end while (q[0] === 1'b1 && n < 3000);
		chk(q[0], 1'b0, "busy clear");
		chk(seen, 1'b1, "busy line seen low");
		chk(i_fcse_card_model.n_done, n0 + 1, "card finished first");
		chk(q[13:8], exp_ca[21:16], "sector field");
		chk(wq.size(), 6, "write count");
		foreach (wq[i]) begin
			c = md[2] ? {seq[i], seq[i]} : ha[0] ? {seq[i], 8'h00} : {8'h00, seq[i]};
			chk(wq[i], {exp_ca, c, ~md[2] & ha[0], ~md[2] & ~ha[0]}, "command write");
		end
		wb(1'b0, REG_IRQ_STAT, 32'h0);
		chk(q, 32'h1, "done event");
		chk(irq, mk[0], "irq level");
		wb(1'b1, REG_IRQ_STAT, 32'h1);
		chk(irq, 1'b0, "irq cleared");
	endtask : erase

	initial begin
		#(25 * 60000);
		n_fail++;
		end_of_test();
	end

	initial begin
		logic [22:0] ha;
		int n;
		int n0;
		void'($urandom(32'hEE8BC5C7));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({cel_n, ceh_n, we_n, oe_n, oe_d}, 5'h1E, "idle card pins");
		wb(1'b1, 8'h14, 32'hFFFFFFFF);
		foreach (rz[i]) begin
			wb(1'b0, rz[i], 32'h0);
			chk(q, 32'h0, "reset value");
		end
		wb(1'b0, REG_STATUS, 32'h0);
		chk(q, 32'h2, "status at reset");
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			ha = 23'($urandom());
			ha[0] = (k % 3 == 2);
			erase(ha, {k == 5, k[0] == 1'b1, k % 3 == 0, 2'b01}, k == 1 ? 3'h0 : 3'h7);
			$display("test erase %0d done", k);
		end
		wq.delete();
		exp_ca = 22'h0091A0;
		n = 0;
		wb(1'b1, REG_IRQ_MASK, 32'h7);
		wb(1'b1, REG_ADDR, 32'h00012340);
		wb(1'b1, REG_CTRL, 32'h5);
		while (i_fcse_card_model.ers == 0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		wb(1'b1, REG_CTRL, 32'h1);
		wb(1'b0, REG_IRQ_STAT, 32'h0);
		chk(q, 32'h4, "second start refused");
		chk(wq.size(), 6, "no extra writes");
		wb(1'b1, REG_IRQ_STAT, 32'h4);
		n0 = i_fcse_card_model.n_abort;
		wb(1'b1, REG_CTRL, 32'h2);
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		wb(1'b0, REG_IRQ_STAT, 32'h0);
		chk(q, 32'h2, "abort event");
		chk(i_fcse_card_model.n_abort, n0 + 1, "card aborted");
		chk(wq[$][17:2], 16'hF0F0, "reset command lanes");
		wb(1'b1, REG_IRQ_STAT, 32'h2);
		erase(23'h012340, 5'h05, 3'h7);
		$display("test abort done");
		end_of_test();
	end
endmodule : tb_top
